// File: pcm_port_pkg.sv
package pcm_port_pkg;

  // Frame shape
  localparam int unsigned NUM_SLOTS = 3;
  localparam int unsigned SAMPLE_W = 16;

  // Clock rates, in kHz, and the fractional divider derived from them
  localparam int unsigned SYS_CLK_PERIOD_PS = 4000;
  localparam int unsigned SYS_CLK_KHZ = 1000000000 / SYS_CLK_PERIOD_PS;
  localparam int unsigned FS_KHZ = 8;
  localparam int unsigned BCLK_LO_KHZ = 2000;
  localparam int unsigned BCLK_HI_KHZ = 2048;
  localparam int unsigned NCO_W = 18;
  localparam logic [NCO_W-1:0] NCO_MOD = NCO_W'(SYS_CLK_KHZ);
  localparam logic [NCO_W-1:0] NCO_STEP_LO = NCO_W'(2 * BCLK_LO_KHZ);
  localparam logic [NCO_W-1:0] NCO_STEP_HI = NCO_W'(2 * BCLK_HI_KHZ);

  // Last bit index of a master frame at each rate
  localparam logic [7:0] FRAME_LAST_LO = 8'(BCLK_LO_KHZ / FS_KHZ - 1);
  localparam logic [7:0] FRAME_LAST_HI = 8'(BCLK_HI_KHZ / FS_KHZ - 1);

  // Register offsets (byte addresses, one word each)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_TX0 = 8'h08;
  localparam logic [7:0] REG_RX0 = 8'h14;

  // Control register fields
  localparam int unsigned CTRL_EN = 0;
  localparam int unsigned CTRL_SLAVE = 1;
  localparam int unsigned CTRL_RATE = 2;
  localparam int unsigned CTRL_FMT = 3;
  localparam int unsigned CTRL_AIR = 5;
  localparam int unsigned CTRL_DIR_A = 7;
  localparam int unsigned CTRL_DIR_B = 8;
  localparam int unsigned CTRL_SLOT = 9;
  localparam int unsigned CTRL_XSYNC = 12;
  localparam int unsigned CTRL_LINW = 15;
  localparam logic [31:0] CTRL_MASK = 32'h0001_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0001_8280;

  // Sample formats and air codings
  localparam logic [1:0] FMT_LINEAR = 2'h0;
  localparam logic [1:0] FMT_ULAW = 2'h1;
  localparam logic [1:0] FMT_ALAW = 2'h2;
  localparam logic [1:0] AIR_CVSD = 2'h0;
  localparam logic [1:0] AIR_ALAW = 2'h1;
  localparam logic [1:0] AIR_ULAW = 2'h2;

  // Sample widths
  localparam logic [4:0] LIN_W_BASE = 5'hd;
  localparam logic [4:0] COMP_W = 5'h8;

  // Status after reset
  localparam logic [2:0] TX_EMPTY_RESET = 3'h7;

endpackage

// File: pcm_sync3.sv
`timescale 1ns/1ps
module pcm_sync3 #(
  parameter int W = 1
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rst,
  // Foreign level and its settled copy
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Stages start at zero: the link clock may not run during reset,
  // so a chain clocked by it would otherwise hold unknowns forever
  logic [W-1:0] s1_r = '0;
  logic [W-1:0] s2_r = '0;
  logic [W-1:0] s3_r = '0;

  // Three-stage chain; only the second stage reads the first
  always_ff @(posedge clk) begin
    s1_r <= d;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  // A bit moves only once stages two and three agree on it
  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= (s3_r & ~(s2_r ^ s3_r)) | (q & (s2_r ^ s3_r));
    end
  end

endmodule

// File: pcm_clk_gen.sv
`timescale 1ns/1ps
module pcm_clk_gen (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Control
  input wire logic run,
  input wire logic rate_hi,
  // Generated bit clock level
  output logic bclk
);

  logic [pcm_port_pkg::NCO_W-1:0] acc_r;
  logic [pcm_port_pkg::NCO_W-1:0] step;
  logic [pcm_port_pkg::NCO_W:0] sum;

  // Fractional divider: 2.048 MHz is no integer ratio of the system
  // clock, so each half period jitters by one system cycle
  assign step = rate_hi ? pcm_port_pkg::NCO_STEP_HI
                        : pcm_port_pkg::NCO_STEP_LO;
  assign sum = {1'b0, acc_r} + {1'b0, step};

  // Toggle the clock each time the accumulator wraps
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      acc_r <= '0;
      bclk <= 1'b0;
    end else if (sum >= {1'b0, pcm_port_pkg::NCO_MOD}) begin
      acc_r <= pcm_port_pkg::NCO_W'(sum - {1'b0, pcm_port_pkg::NCO_MOD});
      bclk <= ~bclk;
    end else begin
      acc_r <= sum[pcm_port_pkg::NCO_W-1:0];
    end
  end

endmodule

// File: pcm_voice_codec_port.sv
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module pcm_voice_codec_port (
  // System clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Air coding selection towards the voice path
  output logic [1:0] air_coding,
  // Bit clock pin; its input is also the link clock
  input wire logic pcm_clk_i,
  output logic pcm_clk_o,
  output logic pcm_clk_oe_n,
  // Frame sync pin
  input wire logic pcm_sync_i,
  output logic pcm_sync_o,
  output logic pcm_sync_oe_n,
  // Data line A
  input wire logic pcm_a_i,
  output logic pcm_a_o,
  output logic pcm_a_oe_n,
  // Data line B
  input wire logic pcm_b_i,
  output logic pcm_b_o,
  output logic pcm_b_oe_n,
  // Extra frame syncs on general-purpose pins 8, 9, 10
  output logic [2:0] gpio_sync_o,
  output logic [2:0] gpio_alt_en
);

  localparam int NS = pcm_port_pkg::NUM_SLOTS;
  localparam int SW = pcm_port_pkg::SAMPLE_W;

  // ---------------- System domain state ----------------
  logic [31:0] ctrl_r;
  logic [SW-1:0] tx_hold_r [0:NS-1];
  logic [SW-1:0] tx_xfer_r [0:NS-1];
  logic [SW-1:0] rx_hold_r [0:NS-1];
  logic [NS-1:0] rx_new_r;
  logic [NS-1:0] tx_empty_r;
  logic [7:0] frame_cnt_r;
  logic frame_seen_r;
  logic frame_tgl_s;
  logic frame_evt;
  logic [31:0] rd_nxt;
  logic [NS-1:0] tx_wr;
  logic [NS-1:0] rx_rd;
  logic en;
  logic slave;
  logic bclk;

  // ---------------- Link domain state ----------------
  logic [12:0] cfg_s;
  logic [12:0] cfg_l;
  logic run_l;
  logic slave_l;
  logic rate_l;
  logic [1:0] fmt_l;
  logic [1:0] linw_l;
  logic [2:0] slot_en_l;
  logic [2:0] xsync_en_l;
  logic [4:0] wid_l;
  logic [SW-1:0] wmask_l;
  logic [7:0] mcnt_r;
  logic [7:0] frame_last;
  logic sync_r;
  logic fs_r;
  logic [1:0] slot_r;
  logic [3:0] bit_r;
  logic [1:0] slot_nxt;
  logic [3:0] bit_nxt;
  logic [4:0] bit_idx;
  logic [SW-1:0] cur_word;
  logic active_nxt;
  logic dout_r;
  logic din;
  logic [2:0] xsync_r;
  logic [SW-1:0] tx_word_r [0:NS-1];
  logic [SW-1:0] rx_sh_r [0:NS-1];
  logic [SW-1:0] rx_xfer_r [0:NS-1];
  logic frame_tgl_r = 1'b0; // No link edges in reset; start defined

  assign en = ctrl_r[pcm_port_pkg::CTRL_EN];
  assign slave = ctrl_r[pcm_port_pkg::CTRL_SLAVE];

  // Decode per-slot data accesses
  always_comb begin
    for (int k = 0; k < NS; k++) begin
      tx_wr[k] = reg_wr && (reg_addr == 8'(pcm_port_pkg::REG_TX0 + 4 * k));
      rx_rd[k] = reg_rd && (reg_addr == 8'(pcm_port_pkg::REG_RX0 + 4 * k));
    end
  end

  // Control register; reset value selects master mode
  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_r <= pcm_port_pkg::CTRL_RESET;
    end else if (reg_wr && reg_addr == pcm_port_pkg::REG_CTRL) begin
      ctrl_r <= reg_wdata & pcm_port_pkg::CTRL_MASK;
    end
  end

  // Air coding is independent of the sample format on the pins
  assign air_coding = ctrl_r[pcm_port_pkg::CTRL_AIR +: 2];

  // Transmit holding words written by software
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < NS; k++) begin
        tx_hold_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NS; k++) begin
        if (tx_wr[k]) begin
          tx_hold_r[k] <= reg_wdata[SW-1:0];
        end
      end
    end
  end

  // Frame boundary toggle from the link side, settled by three stages
  pcm_sync3 #(
    .W(1)
  ) u_frame_sync (
    .clk(clk),
    .rst(reset),
    .d(frame_tgl_r),
    .q(frame_tgl_s)
  );

  always_ff @(posedge clk) begin
    if (reset) begin
      frame_seen_r <= 1'b0;
    end else begin
      frame_seen_r <= frame_tgl_s;
    end
  end

  assign frame_evt = frame_tgl_s != frame_seen_r;

  // Word exchange once a frame. The link side latched its received
  // words on the same edge that toggles and will not touch them, nor read the
  // transmit words, until the next frame start a full frame later
  always_ff @(posedge clk) begin
    if (reset) begin
      for (int k = 0; k < NS; k++) begin
        tx_xfer_r[k] <= '0;
        rx_hold_r[k] <= '0;
      end
    end else if (frame_evt) begin
      for (int k = 0; k < NS; k++) begin
        tx_xfer_r[k] <= tx_hold_r[k];
        if (slot_en_l[k]) begin
          rx_hold_r[k] <= rx_xfer_r[k];
        end
      end
    end
  end

  // Sticky flags: a frame event beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      rx_new_r <= '0;
      tx_empty_r <= pcm_port_pkg::TX_EMPTY_RESET;
      frame_cnt_r <= '0;
    end else begin
      rx_new_r <= ({NS{frame_evt}} & slot_en_l) | (rx_new_r & ~rx_rd);
      tx_empty_r <= ({NS{frame_evt}} & slot_en_l) | (tx_empty_r & ~tx_wr);
      if (frame_evt) begin
        frame_cnt_r <= frame_cnt_r + 8'h1;
      end
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb begin
    rd_nxt = '0;
    if (reg_addr == pcm_port_pkg::REG_CTRL) begin
      rd_nxt = ctrl_r;
    end
    if (reg_addr == pcm_port_pkg::REG_STATUS) begin
      rd_nxt = {16'h0, frame_cnt_r, 2'h0, tx_empty_r, rx_new_r};
    end
    for (int k = 0; k < NS; k++) begin
      if (reg_addr == 8'(pcm_port_pkg::REG_TX0 + 4 * k)) begin
        rd_nxt = {{(32 - SW){1'b0}}, tx_hold_r[k]};
      end
      if (reg_addr == 8'(pcm_port_pkg::REG_RX0 + 4 * k)) begin
        rd_nxt = {{(32 - SW){1'b0}}, rx_hold_r[k]};
      end
    end
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset || !reg_rd) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= rd_nxt;
    end
  end

  // Master bit clock from the system clock
  pcm_clk_gen u_clk_gen (
    .clk(clk),
    .reset(reset),
    .run(en && !slave),
    .rate_hi(ctrl_r[pcm_port_pkg::CTRL_RATE]),
    .bclk(bclk)
  );

  // Pin drivers; output enables are low while the pin is driven, gpio_alt_en is high while in use
  always_ff @(posedge clk) begin
    if (reset) begin
      pcm_clk_o <= 1'b0;
      pcm_clk_oe_n <= 1'b1;
      pcm_sync_oe_n <= 1'b1;
      pcm_a_oe_n <= 1'b1;
      pcm_b_oe_n <= 1'b1;
      gpio_alt_en <= '0;
    end else begin
      pcm_clk_o <= bclk;
      pcm_clk_oe_n <= !(en && !slave);
      pcm_sync_oe_n <= !(en && !slave);
      pcm_a_oe_n <= !(en && ctrl_r[pcm_port_pkg::CTRL_DIR_A]);
      pcm_b_oe_n <= !(en && ctrl_r[pcm_port_pkg::CTRL_DIR_B]);
      gpio_alt_en <= ctrl_r[pcm_port_pkg::CTRL_XSYNC +: 3]
                     & {3{en && !slave}};
    end
  end

  // ---------------- Link domain ----------------

  // Configuration is static while running; each bit crosses on its own
  assign cfg_s = {ctrl_r[pcm_port_pkg::CTRL_XSYNC +: 3],
                  ctrl_r[pcm_port_pkg::CTRL_SLOT +: 3],
                  ctrl_r[pcm_port_pkg::CTRL_LINW +: 2],
                  ctrl_r[pcm_port_pkg::CTRL_FMT +: 2],
                  ctrl_r[pcm_port_pkg::CTRL_RATE], slave, en};

  pcm_sync3 #(
    .W(13)
  ) u_cfg_sync (
    .clk(pcm_clk_i),
    .rst(1'b0),
    .d(cfg_s),
    .q(cfg_l)
  );

  assign {xsync_en_l, slot_en_l, linw_l, fmt_l, rate_l, slave_l, run_l}
    = cfg_l;

  // Sample width and mask
  assign wid_l = (fmt_l == pcm_port_pkg::FMT_LINEAR)
               ? pcm_port_pkg::LIN_W_BASE + {3'h0, linw_l}
               : pcm_port_pkg::COMP_W;
  assign wmask_l = SW'((17'h1 << wid_l) - 17'h1);
  assign frame_last = rate_l ? pcm_port_pkg::FRAME_LAST_HI
                             : pcm_port_pkg::FRAME_LAST_LO;

  // Master frame counter; sync rises one bit ahead of slot 0
  always_ff @(posedge pcm_clk_i) begin
    if (!run_l || slave_l) begin
      mcnt_r <= '0;
      sync_r <= 1'b0;
    end else begin
      mcnt_r <= (mcnt_r == frame_last) ? 8'h0 : mcnt_r + 8'h1;
      sync_r <= (mcnt_r == frame_last);
    end
  end

  assign pcm_sync_o = sync_r;

  // Frame start is the sync level seen at a falling edge
  always_ff @(negedge pcm_clk_i) begin
    if (!run_l) begin
      fs_r <= 1'b0;
    end else begin
      fs_r <= slave_l ? pcm_sync_i : sync_r;
    end
  end

  // Slot and bit position for the coming bit period
  always_comb begin
    slot_nxt = slot_r;
    bit_nxt = bit_r;
    if (fs_r) begin
      slot_nxt = 2'h0;
      bit_nxt = 4'h0;
    end else if (slot_r == 2'(NS)) begin
      slot_nxt = slot_r;
    end else if ({1'b0, bit_r} == wid_l - 5'h1) begin
      slot_nxt = slot_r + 2'h1;
      bit_nxt = 4'h0;
    end else begin
      bit_nxt = bit_r + 4'h1;
    end
  end

  // Transmit word and bit, most significant bit first
  always_comb begin
    cur_word = '0;
    active_nxt = 1'b0;
    if (slot_nxt != 2'(NS)) begin
      active_nxt = slot_en_l[slot_nxt];
      cur_word = fs_r ? tx_xfer_r[0] : tx_word_r[slot_nxt];
    end
    bit_idx = wid_l - 5'h1 - {1'b0, bit_nxt};
  end

  // Position, data and extra syncs all move on the rising edge
  always_ff @(posedge pcm_clk_i) begin
    if (!run_l) begin
      slot_r <= 2'(NS);
      bit_r <= 4'h0;
      dout_r <= 1'b0;
      xsync_r <= '0;
    end else begin
      slot_r <= slot_nxt;
      bit_r <= bit_nxt;
      dout_r <= active_nxt & cur_word[bit_idx[3:0]];
      xsync_r[0] <= xsync_en_l[0] && !slave_l && (mcnt_r == frame_last);
      for (int k = 1; k < NS; k++) begin
        xsync_r[k] <= xsync_en_l[k] && (slot_nxt == 2'(k - 1))
                      && ({1'b0, bit_nxt} == wid_l - 5'h1);
      end
    end
  end

  // Both lines carry the same output bits when both are outputs
  assign pcm_a_o = dout_r;
  assign pcm_b_o = dout_r;
  assign gpio_sync_o = xsync_r;

  // Line A is the input when set so, else line B
  assign din = !cfg_s[0] ? 1'b0
             : !ctrl_r[pcm_port_pkg::CTRL_DIR_A] ? pcm_a_i : pcm_b_i;

  // Receive shift on the falling edge
  always_ff @(negedge pcm_clk_i) begin
    if (!run_l) begin
      for (int k = 0; k < NS; k++) begin
        rx_sh_r[k] <= '0;
      end
    end else begin
      for (int k = 0; k < NS; k++) begin
        if (slot_r == 2'(k) && slot_en_l[k]) begin
          rx_sh_r[k] <= {rx_sh_r[k][SW-2:0], din};
        end
      end
    end
  end

  // At each frame start: hand over last frame, take new words
  always_ff @(posedge pcm_clk_i) begin
    if (!run_l) begin
      frame_tgl_r <= frame_tgl_r;
      for (int k = 0; k < NS; k++) begin
        tx_word_r[k] <= '0;
        rx_xfer_r[k] <= '0;
      end
    end else if (fs_r) begin
      frame_tgl_r <= ~frame_tgl_r;
      for (int k = 0; k < NS; k++) begin
        tx_word_r[k] <= tx_xfer_r[k];
        rx_xfer_r[k] <= rx_sh_r[k] & wmask_l;
      end
    end
  end

endmodule

// File: pcm_port_chk.sv
`timescale 1ns/1ps
module pcm_port_chk (
  // System side
  input wire logic clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic [1:0] air_coding,
  // Pins
  input wire logic pcm_clk_i,
  input wire logic pcm_clk_o,
  input wire logic pcm_clk_oe_n,
  input wire logic pcm_sync_o,
  input wire logic pcm_sync_oe_n,
  input wire logic pcm_a_o,
  input wire logic [2:0] gpio_sync_o,
  input wire logic [2:0] gpio_alt_en
);
  logic [5:0] hi_n;
  logic [8:0] bits_n = 9'h1ff;

  // High phase length of the master clock
  always_ff @(posedge clk) begin
    if (reset || !pcm_clk_o) begin
      hi_n <= 6'h0;
    end else begin
      hi_n <= hi_n + 6'h1;
    end
  end

  // Bits since sync; saturates so a partial first frame is ignored
  always_ff @(posedge pcm_clk_i) begin
    if (pcm_sync_o) begin
      bits_n <= 9'h1;
    end else if (bits_n != 9'h1ff) begin
      bits_n <= bits_n + 9'h1;
    end
  end

  sequence s_frame;
    $rose(pcm_sync_o) && !pcm_sync_oe_n;
  endsequence

  a_air_write: assert property (@(posedge clk) disable iff (reset)
    $changed(air_coding) |-> $past(reg_wr) || $past(reg_wr, 2))
    else $error("air coding moved without a write");
  a_drive_pair: assert property (@(posedge clk) disable iff (reset)
    pcm_clk_oe_n == pcm_sync_oe_n)
    else $error("clock and sync drive differ");
  a_bclk_high: assert property (@(posedge clk) disable iff (reset)
    $fell(pcm_clk_o) |-> hi_n >= 6'h3d && hi_n <= 6'h3f)
    else $error("bit clock high phase off");
  a_data_rise: assert property (@(posedge clk) disable iff (reset)
    $changed(pcm_a_o) |-> pcm_clk_i)
    else $error("data moved while clock low");
  a_sync_width: assert property (@(posedge pcm_clk_i) disable iff (reset)
    s_frame |=> !pcm_sync_o)
    else $error("sync longer than one bit");
  a_frame_len: assert property (@(posedge pcm_clk_i) disable iff (reset)
    s_frame ##0 (bits_n < 9'h12c) |-> bits_n == 9'hfa || bits_n == 9'h100)
    else $error("frame length wrong");
  a_gpio_gate: assert property (@(posedge clk) disable iff (reset)
    |gpio_alt_en |-> !pcm_sync_oe_n)
    else $error("extra sync pin without master");
  a_gpio_dup: assert property (@(posedge pcm_clk_i) disable iff (reset)
    gpio_alt_en[0] |-> gpio_sync_o[0] == pcm_sync_o)
    else $error("first extra sync differs");
endmodule

// File: pcm_codec_model.sv
`timescale 1ns/1ps
module pcm_codec_model (
  // Device pins and mode
  input wire logic pcm_clk_o,
  input wire logic pcm_sync_o,
  input wire logic pcm_clk_oe_n,
  input wire logic run,
  // Data
  input wire logic din,
  input wire logic [47:0] tx_bits,
  output logic dout,
  output logic [47:0] rx_bits,
  // Own clock and sync in slave mode
  output logic clk_s,
  output logic sync_s
);
  int cnt = 48;
  logic bclk;
  logic fs;

  // Four lines: clock, sync and the two data lines
  assign bclk = pcm_clk_oe_n ? clk_s : pcm_clk_o;
  assign fs = pcm_clk_oe_n ? sync_s : pcm_sync_o;

  // Sync at a fall opens a frame; data sampled on falls
  always @(negedge bclk) begin
    if (fs) begin
      cnt <= 0;
    end else if (cnt < 48) begin
      rx_bits <= {rx_bits[46:0], din};
      cnt <= cnt + 1;
    end
  end

  // Drive on rises, MSB first; a released line keeps toggling
  always @(posedge bclk) begin
    dout <= (cnt < 48) ? tx_bits[47 - cnt] : ~dout;
  end

  // Bursts of 64 bits at 12 ns; the clock stands low between frames
  initial begin
    dout = 1'b0;
    clk_s = 1'b0;
    sync_s = 1'b0;
    forever begin
      wait (run && pcm_clk_oe_n);
      #1.7;
      for (int i = 0; i < 64; i++) begin
        #6 clk_s = 1'b1;
        sync_s = (i == 0);
        #6 clk_s = 1'b0;
      end
      #100;
    end
  end
endmodule

// File: tb_pcm_voice_codec_port.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t: got %h want %h", $time, (a), (b)); end end
module tb_pcm_voice_codec_port;
  logic clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, e, w, exp_q[$];
  logic [1:0] air_coding;
  logic [2:0] gpio_sync_o, gpio_alt_en;
  logic pcm_clk_o, pcm_clk_oe_n, pcm_sync_o, pcm_sync_oe_n;
  logic pcm_a_o, pcm_a_oe_n, pcm_b_o, pcm_b_oe_n;
  logic clk_s, sync_s, dout, din, run = 1'b0, rd_d = 1'b0;
  logic [47:0] tx_bits = 48'h0, rx_bits;
  logic [15:0] s0;
  logic [23:0] sb;
  int mismatches = 0, comparisons = 0, n;
  time t;

  // Each pin's level from every party's enable
  wire pcm_clk_i = pcm_clk_oe_n ? clk_s : pcm_clk_o;
  wire pcm_sync_i = pcm_sync_oe_n ? sync_s : pcm_sync_o;
  wire pcm_a_i = pcm_a_oe_n ? dout : pcm_a_o;
  wire pcm_b_i = pcm_b_oe_n ? dout : pcm_b_o;
  assign din = pcm_a_oe_n ? pcm_b_o : pcm_a_o;

  pcm_voice_codec_port dut (.*);
  pcm_codec_model codec (.*);

  initial forever #2 clk = ~clk;

  // Idle cycle after each strobe keeps drivers single per step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      `CHK(reg_rdata, e)
    end
  end

  task automatic test_done;
    if (mismatches == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Two frames at 8 kHz plus margin
  initial begin
    #400000;
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'h7fa0b0ee));
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rd(pcm_port_pkg::REG_CTRL, pcm_port_pkg::CTRL_RESET);
    rd(pcm_port_pkg::REG_STATUS, 32'h38);
    rd(8'hfc, 32'h0);
    `CHK({pcm_clk_oe_n, pcm_sync_oe_n}, 2'h3)
    // Every format and air coding code
    for (int k = 0; k < 3; k++) begin
      w = pcm_port_pkg::CTRL_RESET | (32'(k) << pcm_port_pkg::CTRL_AIR)
        | (32'(k) << pcm_port_pkg::CTRL_FMT);
      wr(pcm_port_pkg::REG_CTRL, w);
      rd(pcm_port_pkg::REG_CTRL, w);
      `CHK(air_coding, 2'(k))
    end
    // Master at 2 MHz, one linear slot
    s0 = 16'($urandom);
    tx_bits <= 48'({$urandom, $urandom});
    wr(pcm_port_pkg::REG_TX0, 32'(s0));
    wr(pcm_port_pkg::REG_CTRL, pcm_port_pkg::CTRL_RESET | 32'h1);
    @(posedge clk);
    `CHK({pcm_clk_oe_n, pcm_sync_oe_n, pcm_a_oe_n, pcm_b_oe_n}, 4'h1)
    @(posedge pcm_clk_o);
    t = $time;
    repeat (10) @(posedge pcm_clk_o);
    `CHK($time - t, 64'h1388)
    // Switch to 2.048 MHz in a low phase, extra syncs on
    @(negedge pcm_clk_o);
    @(posedge clk);
    wr(pcm_port_pkg::REG_CTRL, pcm_port_pkg::CTRL_RESET | 32'h7005);
    @(posedge clk);
    `CHK(gpio_alt_en, 3'h7)
    @(posedge pcm_sync_o);
    #1 t = $time;
    n = 0;
    do begin
      @(posedge pcm_clk_o);
      #1 n++;
    end while (!pcm_sync_o);
    `CHK(n, 256)
    `CHK($time - t, 64'h1e848)
    // Words reach the pins one frame after handover; wait out 48 bits
    repeat (49) @(posedge pcm_clk_o);
    `CHK(rx_bits[47:32], s0)
    @(posedge clk);
    repeat (8) @(posedge clk);
    rd(pcm_port_pkg::REG_RX0, 32'(tx_bits[47:32]));
    // Slave, three 8-bit slots, data lines swapped
    sb = 24'($urandom);
    for (int k = 0; k < 3; k++) begin
      wr(pcm_port_pkg::REG_TX0 + 8'(4 * k), 32'(sb[23 - 8 * k -: 8]));
    end
    @(negedge pcm_clk_o);
    @(posedge clk);
    wr(pcm_port_pkg::REG_CTRL, 32'h0f0b);
    @(posedge clk);
    `CHK({pcm_clk_oe_n, pcm_sync_oe_n, pcm_a_oe_n, pcm_b_oe_n}, 4'he)
    `CHK(gpio_alt_en, 3'h0)
    run <= 1'b1;
    repeat (4) @(posedge sync_s);
    run <= 1'b0;
    repeat (250) @(posedge clk);
    `CHK(rx_bits[47:24], sb)
    for (int k = 0; k < 3; k++) begin
      rd(pcm_port_pkg::REG_RX0 + 8'(4 * k),
        32'(tx_bits[47 - 8 * k -: 8]));
    end
    test_done();
  end
endmodule
bind pcm_voice_codec_port pcm_port_chk chk (.*);
